// File: design/bank_row_ctrl.sv
// Per-bank row activation, precharge, auto-precharge and read data drive window.
//
// What this block does
// RULE1 - An activate takes the bank group, the bank and the fifteen-bit row from the address.
// RULE2 - An activated row stays open until a precharge to its bank or a precharge of all banks.
// RULE3 - The controller precharges a bank before opening another row in it.
// RULE4 - After a precharge the controller waits the recovery time before it activates the bank.
// RULE5 - During an auto-precharge another bank may be accessed if no running transfer is cut.
// RULE6 - A precharged bank is idle and must be activated before any read or write to it.
// RULE7 - A precharge to an idle bank or to a bank already precharging is accepted without error.
// RULE8 - With several precharges to one bank the recovery time counts from the latest one.
// RULE9 - Address bit ten high with a read or write requests auto-precharge of that bank.
// RULE10 - A read auto-precharge waits until the activate-to-precharge minimum has passed.
// RULE11 - A write auto-precharge starts only after the last data beat has been stored.
// RULE12 - A bank shut by auto-precharge may reopen one recovery time after its hidden precharge.
// RULE13 - After a read the data pins are released at read latency plus four or plus two cycles.
// RULE14 - A read uses eight beats on fixed-eight bursts, or on the fly with bit twelve high.
// RULE15 - In on-the-fly mode bit twelve low chops the burst to four beats and high gives eight.
// RULE16 - Each bank is idle, open on a row, or precharging, and commands are checked against it.
`timescale 1ns/1ps
module bank_row_ctrl
    import bank_row_pkg::*;
#(
    parameter int NBANK = 8,
    parameter int CNT_W = 8
) (
    input  wire logic             SYS_CLK,          // System clock, 40 MHz.
    input  wire logic             RST,              // Synchronous reset, active high.
    input  wire logic             CE,               // Clock enable, freezes all state when low.
    input  wire cmd_t             CMD,              // Command slot from the controller.
    input  wire logic [1:0]       BURST_MODE,       // Burst-length field of burst_config_register.
    input  wire logic [LAT_W-1:0] READ_LATENCY,     // read_latency in clock cycles.
    input  wire logic [LAT_W-1:0] WRITE_LATENCY,    // Write latency in clock cycles.
    output bank_view_t            BANK_VIEW,        // Registered per-bank state flags.
    output logic [ROW_W-1:0]      OPEN_ROW,         // Stored row of the last addressed bank.
    output logic                  DQ_OE,            // High while the data pins are driven.
    output logic                  EIGHT_BEAT_BURST, // Length of the last read or write.
    output logic                  CMD_ERR           // One-cycle pulse on an illegal command.
);

    // Refuse sizes the logic cannot serve.
    if (NBANK != (1 << BANK_W)) begin : g_bad_banks
        $error("bank_row_ctrl needs exactly eight banks.");
    end
    if ((RP_CYC >= (1 << CNT_W)) || (RAS_CYC >= (1 << CNT_W))) begin : g_bad_cnt
        $error("bank_row_ctrl counter width too small for core times.");
    end
    if (CNT_W < LAT_W + 2) begin : g_bad_lat
        $error("bank_row_ctrl counter width too small for latencies.");
    end

    localparam logic [CNT_W-1:0] RP_LOAD  = CNT_W'(RP_CYC - 1);
    localparam logic [CNT_W-1:0] RAS_DONE = CNT_W'(RAS_CYC);
    localparam logic [CNT_W-1:0] BL8_CNT  = CNT_W'(EIGHT_BEAT_CYC);
    localparam logic [CNT_W-1:0] BC4_CNT  = CNT_W'(FOUR_BEAT_CYC);

    // Bank index from bank group and bank address.
    function automatic logic [BANK_W-1:0] bank_of(input cmd_t c);
        bank_of = {c.bg, c.ba}; // [RULE1]
    endfunction : bank_of

    // Command decode.
    wire              cmd_v    = CMD.valid;
    wire              is_act   = cmd_v && (CMD.op == OP_ACT);
    wire              is_pre   = cmd_v && (CMD.op == OP_PRE);
    wire              is_prea  = cmd_v && (CMD.op == OP_PREA);
    wire              is_rd    = cmd_v && (CMD.op == OP_RD);
    wire              is_wr    = cmd_v && (CMD.op == OP_WR);
    wire              is_rw    = is_rd || is_wr;
    wire [BANK_W-1:0] bank_sel = bank_of(CMD);
    wire              ap_req   = CMD.addr[AP_BIT];  // [RULE9]
    wire              otf_high = CMD.addr[OTF_BIT];

    // Burst length chosen by the field and, on the fly, by bit twelve.
    wire eight_now = (BURST_MODE == BL_FIXED_EIGHT) ||
                     ((BURST_MODE == BL_ON_THE_FLY) && otf_high); // [RULE14] [RULE15]
    wire [CNT_W-1:0] beats_cyc = eight_now ? BL8_CNT : BC4_CNT;

    // Cycles from a write command until its last beat sits in the array.
    wire [CNT_W-1:0] wr_store = CNT_W'(WRITE_LATENCY) + beats_cyc; // [RULE11]

    logic [NBANK-1:0] act_v;
    logic [NBANK-1:0] pre_v;
    logic [NBANK-1:0] ap_v;
    logic [NBANK-1:0] err_v;

    // Per-bank state machines with their timers.
    for (genvar b = 0; b < NBANK; b++) begin : g_bank
        bank_st_t         st_ff;
        bank_st_t         nxt_st;
        logic [CNT_W-1:0] ras_ff;
        logic [CNT_W-1:0] nxt_ras;
        logic [CNT_W-1:0] rp_ff;
        logic [CNT_W-1:0] nxt_rp;
        logic [CNT_W-1:0] apw_ff;
        logic [CNT_W-1:0] nxt_apw;
        logic             ap_ff;
        logic             nxt_ap;

        wire sel      = cmd_v && (bank_sel == BANK_W'(b));
        wire pre_hit  = (is_pre && sel) || is_prea;          // [RULE2]
        wire act_hit  = is_act && sel;
        wire rw_hit   = is_rw && sel && (st_ff == B_ACT);
        wire ras_done = (ras_ff >= RAS_DONE);
        wire ap_go    = ap_ff && (apw_ff == '0) && ras_done; // [RULE10] [RULE11]
        wire rp_over  = (st_ff == B_PRE) && (rp_ff == '0);    // Last cycle of recovery.
        wire act_ok   = (st_ff == B_IDLE) || rp_over;         // [RULE4] [RULE12]

        // Next state: explicit precharge wins over a pending auto-precharge.
        always_comb begin
            nxt_st  = st_ff;
            nxt_ras = ras_done ? ras_ff : ras_ff + CNT_W'(1);
            nxt_rp  = (rp_ff != '0) ? rp_ff - CNT_W'(1) : rp_ff;
            nxt_apw = (apw_ff != '0) ? apw_ff - CNT_W'(1) : apw_ff;
            nxt_ap  = ap_ff;
            case (st_ff)
                B_IDLE: begin
                    if (act_hit) begin // [RULE16]
                        nxt_st  = B_ACT;
                        nxt_ras = '0;
                        nxt_ap  = 1'b0;
                    end
                end
                B_ACT: begin
                    if (pre_hit) begin // [RULE2]
                        nxt_st = B_PRE;
                        nxt_rp = RP_LOAD;
                        nxt_ap = 1'b0;
                    end else if (ap_go) begin // [RULE12]
                        nxt_st = B_PRE;
                        nxt_rp = RP_LOAD;
                        nxt_ap = 1'b0;
                    end else if (rw_hit && ap_req) begin // [RULE9]
                        nxt_ap  = 1'b1;
                        nxt_apw = is_wr ? wr_store : '0;
                    end
                end
                B_PRE: begin
                    if (pre_hit) begin // [RULE8]
                        nxt_rp = RP_LOAD;
                    end else if (act_hit && act_ok) begin // [RULE12]
                        nxt_st  = B_ACT;
                        nxt_ras = '0;
                    end else if (rp_ff == '0) begin // [RULE4] [RULE12]
                        nxt_st = B_IDLE;
                    end
                end
                default: begin
                    nxt_st = B_IDLE;
                end
            endcase
        end

        // Bank registers.
        always_ff @(posedge SYS_CLK) begin
            if (RST) begin
                st_ff  <= B_IDLE;
                ras_ff <= '0;
                rp_ff  <= '0;
                apw_ff <= '0;
                ap_ff  <= 1'b0;
            end else if (CE) begin
                st_ff  <= nxt_st;
                ras_ff <= nxt_ras;
                rp_ff  <= nxt_rp;
                apw_ff <= nxt_apw;
                ap_ff  <= nxt_ap;
            end
        end

        // A precharge to an idle or precharging bank is never an error.
        assign err_v[b] = (act_hit && !act_ok) ||
                          (is_rw && sel && (st_ff != B_ACT)); // [RULE3] [RULE6] [RULE7] [RULE16]
        assign act_v[b] = (nxt_st == B_ACT);
        assign pre_v[b] = (nxt_st == B_PRE);
        assign ap_v[b]  = nxt_ap;
    end

    wire cmd_bad = |err_v;

    // Open row addresses, written on every legal activate.
    wire row_wr = is_act && !cmd_bad; // [RULE1]

    row_store #(
        .DEPTH (NBANK),
        .AW    (BANK_W),
        .DW    (ROW_W)
    ) u_rows (
        .clk     (SYS_CLK),
        .rst     (RST),
        .ce      (CE),
        .wr_en   (row_wr),
        .wr_addr (bank_sel),
        .wr_data (CMD.addr),
        .rd_addr (bank_sel),
        .rd_data (OPEN_ROW)
    );

    // Read data window: age counts from the read command edge.
    logic             rd_run_ff;
    logic [CNT_W-1:0] age_ff;
    logic [CNT_W-1:0] start_ff;
    logic [CNT_W-1:0] end_ff;

    // A new read restarts the window; the controller keeps reads from cutting a burst short.
    wire              rd_go     = is_rd && !cmd_bad; // [RULE5]
    wire [CNT_W-1:0]  rl_cnt    = CNT_W'(READ_LATENCY);
    wire              nxt_run   = rd_go || (rd_run_ff && (age_ff < end_ff));
    wire [CNT_W-1:0]  nxt_age   = rd_go ? '0 :
                                  (rd_run_ff ? age_ff + CNT_W'(1) : age_ff);
    wire [CNT_W-1:0]  nxt_start = rd_go ? rl_cnt : start_ff;
    wire [CNT_W-1:0]  nxt_end   = rd_go ? rl_cnt + beats_cyc : end_ff; // [RULE13]
    wire              nxt_oe    = nxt_run && (nxt_age >= nxt_start) &&
                                  (nxt_age < nxt_end); // [RULE13]

    // Read window registers.
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            rd_run_ff <= 1'b0;
            age_ff    <= '0;
            start_ff  <= '0;
            end_ff    <= '0;
        end else if (CE) begin
            rd_run_ff <= nxt_run;
            age_ff    <= nxt_age;
            start_ff  <= nxt_start;
            end_ff    <= nxt_end;
        end
    end

    // Registered outputs.
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            BANK_VIEW        <= '0;
            DQ_OE            <= 1'b0;
            EIGHT_BEAT_BURST <= 1'b1;
            CMD_ERR          <= 1'b0;
        end else if (CE) begin
            BANK_VIEW        <= '{active: act_v, precharging: pre_v, ap_pending: ap_v};
            DQ_OE            <= nxt_oe;
            CMD_ERR          <= cmd_bad; // [RULE16]
            if (is_rw) begin
                EIGHT_BEAT_BURST <= eight_now; // [RULE14]
            end
        end
    end

endmodule : bank_row_ctrl

// File: design/bank_row_pkg.sv
// Shared constants, command encodings and carrier types for the bank row state block.
package bank_row_pkg;

    // Command opcodes carried in the command struct.
    localparam logic [2:0] OP_NOP  = 3'h0;
    localparam logic [2:0] OP_ACT  = 3'h1;
    localparam logic [2:0] OP_PRE  = 3'h2;
    localparam logic [2:0] OP_PREA = 3'h3;
    localparam logic [2:0] OP_RD   = 3'h4;
    localparam logic [2:0] OP_WR   = 3'h5;

    // Address geometry and special address bits.
    localparam int ROW_W   = 15;
    localparam int BANK_W  = 3;
    localparam int AP_BIT  = 10;
    localparam int OTF_BIT = 12;
    localparam int LAT_W   = 6;

    // Burst-length field encodings of the burst configuration.
    localparam logic [1:0] BL_FIXED_EIGHT = 2'h0;
    localparam logic [1:0] BL_ON_THE_FLY  = 2'h1;

    // Clock cycles that a burst occupies on the data pins.
    localparam int EIGHT_BEAT_CYC = 4;
    localparam int FOUR_BEAT_CYC  = 2;

    // Core times in nanoseconds and the clock rate used to convert them.
    localparam int CLK_MHZ                      = 40;
    localparam int PRECHARGE_RECOVERY_TIME_NS   = 15;
    localparam int ACTIVATE_TO_PRECHARGE_MIN_NS = 33;

    // Least times round up to whole cycles and never fall below one cycle.
    localparam int RP_RAW  = (PRECHARGE_RECOVERY_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int RAS_RAW = (ACTIVATE_TO_PRECHARGE_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int RP_CYC  = (RP_RAW < 1) ? 1 : RP_RAW;
    localparam int RAS_CYC = (RAS_RAW < 1) ? 1 : RAS_RAW;

    // One command slot from the controller.
    typedef struct packed {
        logic             valid;
        logic [2:0]       op;
        logic             bg;
        logic [1:0]       ba;
        logic [ROW_W-1:0] addr;
    } cmd_t;

    // Per-bank state, one-hot.
    typedef enum logic [2:0] {
        B_IDLE = 3'b001,
        B_ACT  = 3'b010,
        B_PRE  = 3'b100
    } bank_st_t;

    // Registered view of all eight banks.
    typedef struct packed {
        logic [7:0] active;
        logic [7:0] precharging;
        logic [7:0] ap_pending;
    } bank_view_t;

endpackage : bank_row_pkg

// File: design/row_store.sv
// Small memory holding the open row address of each bank, registered read port.
`timescale 1ns/1ps
module row_store #(
    parameter int DEPTH = 8,
    parameter int AW    = 3,
    parameter int DW    = 15
) (
    input  wire logic          clk,     // System clock.
    input  wire logic          rst,     // Synchronous reset, clears the read register.
    input  wire logic          ce,      // Clock enable.
    input  wire logic          wr_en,   // Write strobe.
    input  wire logic [AW-1:0] wr_addr, // Write address.
    input  wire logic [DW-1:0] wr_data, // Write data.
    input  wire logic [AW-1:0] rd_addr, // Read address.
    output logic      [DW-1:0] rd_data  // Registered read data.
);

    logic [DW-1:0] mem [DEPTH];

    // Refuse a depth that the address cannot reach.
    if (DEPTH > (1 << AW)) begin : g_bad_depth
        $error("row_store depth exceeds address range.");
    end

    // Array write.
    always_ff @(posedge clk) begin
        if (ce && wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Registered read.
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_data <= '0;
        end else if (ce) begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule : row_store

// File: test/bank_row_ctrl_assertions.sv
// Concurrent checks on the ports of the bank row state block.
`timescale 1ns/1ps
module bank_row_ctrl_checker
    import bank_row_pkg::*;
(
    input wire logic             SYS_CLK,          // System clock.
    input wire logic             RST,              // Synchronous reset.
    input wire logic             CE,               // Clock enable.
    input wire cmd_t             CMD,              // Command slot.
    input wire logic [1:0]       BURST_MODE,       // Burst field.
    input wire logic [LAT_W-1:0] READ_LATENCY,     // Read latency.
    input wire bank_view_t       BANK_VIEW,        // Bank flags.
    input wire logic             DQ_OE,            // Data drive.
    input wire logic             EIGHT_BEAT_BURST, // Burst length.
    input wire logic             CMD_ERR           // Error pulse.
);
    // Decode of the command slot.
    wire logic [2:0] bk   = {CMD.bg, CMD.ba};
    wire logic       take = CE && CMD.valid;
    wire logic       rd   = take && CMD.op == OP_RD;
    wire logic       rw   = take && (CMD.op == OP_RD || CMD.op == OP_WR);
    wire logic       pre  = take && (CMD.op == OP_PRE || CMD.op == OP_PREA);
    wire logic       e8   = BURST_MODE == BL_FIXED_EIGHT
                            || (BURST_MODE == BL_ON_THE_FLY && CMD.addr[OTF_BIT]);
    logic [2:0] bk_ff;
    logic       e8_ff;
    // Remembers the addressed bank and burst choice for the following cycle.
    always_ff @(posedge SYS_CLK) begin
        bk_ff <= bk;
        e8_ff <= e8;
    end
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    chk_act_opens_bank: assert property (
        take && CMD.op == OP_ACT && !BANK_VIEW.active[bk] && !BANK_VIEW.precharging[bk]
        |=> BANK_VIEW.active[bk_ff] && !CMD_ERR) else $error("activate did not open bank");
    chk_rw_idle_err: assert property (
        rw && !BANK_VIEW.active[bk] |=> CMD_ERR) else $error("access to closed bank not flagged");
    chk_pre_closes_row: assert property (
        take && CMD.op == OP_PRE && BANK_VIEW.active[bk]
        |=> !BANK_VIEW.active[bk_ff] && BANK_VIEW.precharging[bk_ff])
        else $error("precharge did not close the row");
    chk_row_stays_open: assert property (
        CE && !pre && BANK_VIEW.ap_pending == 8'h0
        |=> ($past(BANK_VIEW.active) & ~BANK_VIEW.active) == 8'h0)
        else $error("row closed without a precharge");
    chk_pre_no_error: assert property (
        pre |=> !CMD_ERR) else $error("precharge flagged as error");
    chk_ap_arms: assert property (
        rw && BANK_VIEW.active[bk] && CMD.addr[AP_BIT]
        |=> BANK_VIEW.ap_pending[bk_ff] || BANK_VIEW.precharging[bk_ff])
        else $error("auto-precharge not engaged");
    chk_burst_length: assert property (
        rw && BANK_VIEW.active[bk] |=> EIGHT_BEAT_BURST == e8_ff)
        else $error("wrong burst length");
    chk_eight_release: assert property (
        rd && BANK_VIEW.active[bk] && READ_LATENCY == 6'h0 && e8 ##1 (CE && !rd)[*4]
        |-> DQ_OE ##1 !DQ_OE) else $error("data pins not released after eight beats");
    cov_read: cover property (rd && BANK_VIEW.active[bk]);
    cov_error: cover property (CMD_ERR);
    cov_auto_pre: cover property (BANK_VIEW.ap_pending != 8'h0);
endmodule : bank_row_ctrl_checker
bind bank_row_ctrl bank_row_ctrl_checker u_chk (.SYS_CLK(SYS_CLK), .RST(RST), .CE(CE),
    .CMD(CMD), .BURST_MODE(BURST_MODE), .READ_LATENCY(READ_LATENCY), .BANK_VIEW(BANK_VIEW),
    .DQ_OE(DQ_OE), .EIGHT_BEAT_BURST(EIGHT_BEAT_BURST), .CMD_ERR(CMD_ERR));

// File: test/ctrl_model.sv
// Behavioural memory controller that presents commands to the bank row block.
`timescale 1ns/1ps
module ctrl_model
    import bank_row_pkg::*;
(
    input  wire logic SYS_CLK, // System clock.
    output cmd_t      CMD      // Command slot towards the device.
);
    int pre_at[8];
    int cyc = 0;
    // Cycle count used to space an activate after a precharge.
    always @(posedge SYS_CLK) cyc <= cyc + 1;
    initial CMD = '0;
    initial foreach (pre_at[i]) pre_at[i] = -100;
    // Drives one command for one cycle, then idles with every field turned over.
    task automatic issue(input logic [2:0] op, input logic [2:0] bk, input logic [14:0] a);
        cmd_t c;
        c = {1'b1, op, bk, a};
        @(posedge SYS_CLK);
        while (op == OP_ACT && cyc - pre_at[bk] <= RP_CYC) @(posedge SYS_CLK);
        CMD <= c;
        if (op == OP_PRE) pre_at[bk] = cyc;
        if (op == OP_PREA) foreach (pre_at[i]) pre_at[i] = cyc;
        @(posedge SYS_CLK);
        CMD <= {1'b0, ~c[20:0]};
        #1;
    endtask : issue
endmodule : ctrl_model

// File: test/tb.sv
// Self-checking testbench for the bank row state block.
`timescale 1ns/1ps
module tb;
    import bank_row_pkg::*;
    logic             sys_clk = 1'b0;
    logic             rst = 1'b1;
    logic             ce = 1'b1;
    logic [1:0]       burst_mode = 2'h0;
    logic [LAT_W-1:0] rl = 6'h0;
    logic [LAT_W-1:0] wl = 6'h2;
    cmd_t             cmd;
    bank_view_t       view;
    logic [ROW_W-1:0] open_row;
    logic             dq_oe;
    logic             eight;
    logic             cmd_err;
    int               err_total = 0;
    int               checks = 0;
    int               cyc = 0;
    int               seed = 65830;
    int               st[8];
    int               row[8];
    // Clock at 40 MHz.
    always #12.5 sys_clk = ~sys_clk;
    ctrl_model pm (.SYS_CLK(sys_clk), .CMD(cmd));
    bank_row_ctrl dut (.SYS_CLK(sys_clk), .RST(rst), .CE(ce), .CMD(cmd),
        .BURST_MODE(burst_mode), .READ_LATENCY(rl), .WRITE_LATENCY(wl), .BANK_VIEW(view),
        .OPEN_ROW(open_row), .DQ_OE(dq_oe), .EIGHT_BEAT_BURST(eight), .CMD_ERR(cmd_err));
    // Compares one value and counts it.
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic end_of_test();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test
    // Cuts a hung run short.
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            end_of_test();
        end
    end
    // Sends one command and compares error and bank flags with the bank model.
    task automatic do_cmd(input logic [2:0] op, input int b, input logic [14:0] a);
        logic e;
        e = 1'b0;
        foreach (st[i]) if (st[i] == 2) st[i] = 0;
        if (op == OP_ACT && st[b] == 0) begin
            st[b] = 1;
            row[b] = a;
        end else if (op == OP_ACT || ((op == OP_RD || op == OP_WR) && st[b] != 1)) begin
            e = 1'b1;
        end else if (op == OP_PRE && st[b] == 1) begin
            st[b] = 2;
        end else if (op == OP_PREA) begin
            foreach (st[i]) if (st[i] == 1) st[i] = 2;
        end
        pm.issue(op, 3'(b), a);
        chk("cmd_err", e, cmd_err);
        foreach (st[i]) chk("active", st[i] == 1, view.active[i]);
        foreach (st[i]) chk("precharging", st[i] == 2, view.precharging[i]);
    endtask : do_cmd
    initial begin
        int len;
        repeat (20) @(posedge sys_clk);
        #1;
        chk("view", 0, view);
        chk("eight", 1, eight);
        chk("dq_oe", 0, dq_oe | cmd_err);
        @(posedge sys_clk);
        rst <= 1'b0;
        // Opens every bank, then tries to reopen one that is open.
        for (int b = 0; b < 8; b++) do_cmd(OP_ACT, b, 15'($random(seed)));
        do_cmd(OP_ACT, 3, 15'h0000);
        // Reads in burst modes 0 to 2 and read latencies 0 to 3, with the data drive window.
        for (int k = 0; k < 6; k++) begin
            burst_mode <= 2'(k % 3);
            rl <= 6'(k % 4);
            len = (k % 3 == 0 || k == 4) ? 4 : 2;
            do_cmd(OP_RD, k, 15'(k / 3) << OTF_BIT);
            chk("eight", len == 4, eight);
            chk("open_row", row[k], open_row);
            for (int i = 0; i <= k % 4 + len; i++) begin
                chk("dq_oe", i >= k % 4 && i < k % 4 + len, dq_oe);
                @(posedge sys_clk);
                #1;
            end
        end
        // Precharges, repeats on idle banks, and refuses a read of a closed bank.
        do_cmd(OP_PRE, 0, 15'h0000);
        do_cmd(OP_PRE, 0, 15'h0000);
        do_cmd(OP_RD, 0, 15'h0000);
        do_cmd(OP_ACT, 0, 15'h1234);
        do_cmd(OP_PREA, 0, 15'h0000);
        do_cmd(OP_PREA, 5, 15'h0000);
        // Write with auto-precharge: hidden precharge follows the stored data.
        burst_mode <= 2'h1;
        wl <= 6'h3;
        do_cmd(OP_ACT, 2, 15'h0042);
        do_cmd(OP_WR, 2, 15'h0400);
        chk("ap_pending", 1, view.ap_pending[2]);
        for (int i = 1; i <= 7; i++) begin
            @(posedge sys_clk);
            #1;
            chk("wr_ap_pre", i == 6, view.precharging[2]);
        end
        st[2] = 0;
        // Short read with auto-precharge, then a read of another bank right after its burst.
        rl <= 6'h0;
        do_cmd(OP_ACT, 6, 15'h0011);
        do_cmd(OP_ACT, 2, 15'h0077);
        do_cmd(OP_RD, 2, 15'h0400);
        pm.issue(OP_RD, 3'h6, 15'h0000);
        chk("cmd_err", 0, cmd_err);
        chk("dq_oe", 1, dq_oe);
        repeat (6) @(posedge sys_clk);
        #1;
        chk("rd_ap", 0, view.active[2] | view.ap_pending[2] | view.precharging[2]);
        st[2] = 0;
        do_cmd(OP_ACT, 2, 15'h0005);
        // A precharge offered while the clock enable is low must leave every row open.
        ce <= 1'b0;
        pm.issue(OP_PREA, 3'h0, 15'h0000);
        foreach (st[i]) chk("ce_hold", st[i] == 1, view.active[i]);
        chk("ce_err", 0, cmd_err);
        ce <= 1'b1;
        end_of_test();
    end
endmodule : tb
